// ==== core/iwd_map.svh ====
`ifndef IWD_MAP_SVH
`define IWD_MAP_SVH
`define IWD_OFF_MAIN 12'h000
`define IWD_OFF_XFER 12'h004
`define IWD_OFF_STAT 12'h008
`define IWD_MAIN_RESET 32'h00000000
`define IWD_XFER_RESET 32'h00000000
`define IWD_MAIN_WMASK 32'h00ffdfff
`define IWD_XFER_WMASK 32'h07ffffff
`define IWD_LOCK_MASK 32'h00021f00
`define IWD_B_EN 0
`define IWD_B_TXIE 1
`define IWD_B_RXIE 2
`define IWD_B_ADIE 3
`define IWD_B_NKIE 4
`define IWD_B_SPIE 5
`define IWD_B_TRANSFER_DONE_IRQ_ENABLE 6
`define IWD_B_ERIE 7
`define IWD_B_DNF_LO 8
`define IWD_B_DNF_HI 11
`define IWD_B_ANALOG_FILTER_OFF 12
`define IWD_B_DTX 14
`define IWD_B_DRX 15
`define IWD_B_SBC 16
`define IWD_B_SS 17
`define IWD_B_WAKE 18
`define IWD_B_GC 19
`define IWD_B_HA 20
`define IWD_B_DA 21
`define IWD_B_ALT 22
`define IWD_B_PEC 23
`define IWD_ADDR_GC 7'h00
`define IWD_ADDR_HOST 7'h08
`define IWD_ADDR_DEF 7'h61
`define IWD_OSC_WAIT 8'h08
`endif

// ==== core/iwd_pkg.sv ====
package iwd_pkg;
  typedef enum logic [2:0] {
    IWD_AWAKE, IWD_IDLE, IWD_OSC_UP, IWD_ADDR, IWD_HOLD
  } iwd_sleep_e;
  typedef struct packed {
    logic rx_full;
    logic tx_empty;
    logic stop_seen;
    logic count_reload;
    logic transfer_done;
    logic addr_match;
    logic not_ack;
  } iwd_events_s;
  typedef struct packed {
    logic bus_error;
    logic arbitration_loss;
    logic over_under_run;
    logic checksum_mismatch;
    logic timeout;
  } iwd_faults_s;
endpackage : iwd_pkg

// ==== core/iwd_ctrl.sv ====
`timescale 1ns/1ns
`include "iwd_map.svh"
module iwd_ctrl
  import iwd_pkg::*;
#(
  parameter bit FIRST_INSTANCE = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire iwd_events_s events,
  input wire iwd_faults_s faults,
  input wire logic addr_match_clear,
  input wire logic deep_sleep,
  input wire logic kernel_is_fast_osc,
  input wire logic osc_ready,
  input wire logic start_seen,
  input wire logic [6:0] rx_addr,
  input wire logic addr_valid,
  input wire logic core_halted,
  input wire logic debug_freeze_select,
  input wire logic alert_pin_in,
  input wire logic scl_in,
  output logic osc_request,
  output logic wake_request,
  output logic scl_hold_low,
  output logic special_addr_ack,
  output logic dma_tx_req,
  output logic dma_rx_req,
  output logic event_irq,
  output logic alert_pin_out,
  output logic alert_pin_oe,
  output logic alert_seen_flag,
  output logic timeout_run,
  output logic [31:0] control_bits
);
  logic [31:0] main_reg;
  logic [31:0] xfer_reg;
  logic [1:0] alert_sync_reg;
  logic alert_last_reg;
  logic [1:0] scl_sync_reg;
  logic [1:0] osc_sync_reg;
  logic tx_last_reg;
  logic rx_last_reg;
  logic [7:0] osc_cnt_reg;
  iwd_sleep_e sleep_state_reg;
  logic acc;
  logic setup;
  logic wr;
  logic [31:0] wr_main;
  logic alert_level;
  logic host_mode;
  logic addr_hit;
  logic ev_term;
  logic err_term;

  // apb access decode, zero wait states
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign setup = psel && !penable;
  assign host_mode = main_reg[`IWD_B_HA];

  // lock fields while enabled, wake bit only with filter zero
  // the filter, analog filter and stretch fields keep their value while enabled,
  // so software cannot change the line conditioning under a live transfer
  always_comb begin
    wr_main = (pwdata & `IWD_MAIN_WMASK) | (main_reg & ~`IWD_MAIN_WMASK);
    if (main_reg[`IWD_B_EN]) begin
      wr_main = (wr_main & ~`IWD_LOCK_MASK) | (main_reg & `IWD_LOCK_MASK);
    end
    if (!FIRST_INSTANCE || wr_main[`IWD_B_DNF_HI:`IWD_B_DNF_LO] != 4'h0) begin
      wr_main[`IWD_B_WAKE] = 1'b0;
    end
  end

  // control_main register, written through the lock mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_reg <= `IWD_MAIN_RESET;
    end else if (wr && paddr == `IWD_OFF_MAIN) begin
      main_reg <= wr_main;
    end
  end

  // control_transfer register, plain storage, only read back over apb
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_reg <= `IWD_XFER_RESET;
    end else if (wr && paddr == `IWD_OFF_XFER) begin
      xfer_reg <= pwdata & `IWD_XFER_WMASK;
    end
  end

  // answer in the cycle after setup, never a wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // error answer for offsets that hold no register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup && paddr != `IWD_OFF_MAIN && paddr != `IWD_OFF_XFER &&
                 paddr != `IWD_OFF_STAT;
    end
  end

  // read mux, captured in the setup cycle; unmapped offsets read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      case (paddr)
        `IWD_OFF_MAIN: prdata <= main_reg;
        `IWD_OFF_XFER: prdata <= xfer_reg;
        `IWD_OFF_STAT: prdata <= {19'h00000, alert_seen_flag, faults, events};
        default: prdata <= 32'h00000000;
      endcase
    end else begin
      prdata <= 32'h00000000;
    end
  end

  // alert pin synchroniser, idles high like the pulled-up line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_sync_reg <= 2'h3;
    end else begin
      alert_sync_reg <= {alert_sync_reg[0], alert_pin_in};
    end
  end

  // bus clock synchroniser, idles high like the pulled-up line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync_reg <= 2'h3;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
    end
  end

  // oscillator ready synchroniser, the ready comes from another clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_sync_reg <= 2'h0;
    end else begin
      osc_sync_reg <= {osc_sync_reg[0], osc_ready};
    end
  end

  // previous alert level for the falling edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_last_reg <= 1'b1;
    end else begin
      alert_last_reg <= alert_level;
    end
  end

  // alert line forced high unless host alert enabled
  assign alert_level = (main_reg[`IWD_B_ALT] && host_mode) ? alert_sync_reg[1] : 1'b1;

  // alert flag: set beats clear
  // a clear that meets a new edge loses, so no alert is ever dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_seen_flag <= 1'b0;
    end else if (alert_last_reg && !alert_level) begin
      alert_seen_flag <= 1'b1;
    end else if (wr && paddr == `IWD_OFF_STAT && pwdata[19]) begin
      alert_seen_flag <= 1'b0;
    end
  end

  // alert pin level: only ever pulls the line low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_pin_out <= 1'b1;
    end else begin
      alert_pin_out <= 1'b0;
    end
  end

  // alert pin drive in device mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_pin_oe <= 1'b0;
    end else begin
      alert_pin_oe <= main_reg[`IWD_B_ALT] && !host_mode;
    end
  end

  // special address matching
  // only the fixed bus addresses are decoded here, own addresses live elsewhere
  assign addr_hit = (main_reg[`IWD_B_GC] && rx_addr == `IWD_ADDR_GC) ||
                    (main_reg[`IWD_B_HA] && rx_addr == `IWD_ADDR_HOST) ||
                    (main_reg[`IWD_B_DA] && rx_addr == `IWD_ADDR_DEF);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      special_addr_ack <= 1'b0;
    end else begin
      special_addr_ack <= addr_valid && main_reg[`IWD_B_EN] && addr_hit;
    end
  end

  // dma write request, one pulse per rising transmit flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_last_reg <= 1'b0;
      dma_tx_req <= 1'b0;
    end else begin
      tx_last_reg <= events.tx_empty;
      dma_tx_req <= main_reg[`IWD_B_DTX] && events.tx_empty && !tx_last_reg;
    end
  end

  // dma read request, one pulse per rising receive flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_last_reg <= 1'b0;
      dma_rx_req <= 1'b0;
    end else begin
      rx_last_reg <= events.rx_full;
      dma_rx_req <= main_reg[`IWD_B_DRX] && events.rx_full && !rx_last_reg;
    end
  end

  // event and error interrupt terms
  // levels, not edges: the line stays up until the flag or enable drops
  assign ev_term = (events.rx_full && main_reg[`IWD_B_RXIE]) ||
                   (events.tx_empty && main_reg[`IWD_B_TXIE]) ||
                   (events.stop_seen && main_reg[`IWD_B_SPIE]) ||
                   (events.addr_match && main_reg[`IWD_B_ADIE]) ||
                   (events.not_ack && main_reg[`IWD_B_NKIE]) ||
                   ((events.count_reload || events.transfer_done) && main_reg[`IWD_B_TRANSFER_DONE_IRQ_ENABLE]);
  assign err_term = main_reg[`IWD_B_ERIE] && ((|faults) || alert_seen_flag);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_irq <= 1'b0;
    end else begin
      event_irq <= ev_term || err_term;
    end
  end

  // timeout counter enable under debug halt
  // freezing keeps a breakpoint from turning into a false bus timeout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_run <= 1'b1;
    end else begin
      timeout_run <= !(core_halted && debug_freeze_select);
    end
  end

  // control field outputs for the transfer engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_bits <= 32'h00000000;
    end else begin
      control_bits <= main_reg;
    end
  end

  // deep sleep wakeup sequencer
  // armed only while asleep with wake enabled and the fast oscillator as source;
  // the oscillator must be counted stable before the address is sampled,
  // otherwise the first address bits would be clocked by a ramping clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_state_reg <= IWD_AWAKE;
      osc_cnt_reg <= 8'h00;
    end else begin
      case (sleep_state_reg)
        IWD_AWAKE: begin
          if (deep_sleep && main_reg[`IWD_B_WAKE] && kernel_is_fast_osc) begin
            sleep_state_reg <= IWD_IDLE;
          end
        end
        IWD_IDLE: begin
          if (!deep_sleep || !main_reg[`IWD_B_WAKE] || !kernel_is_fast_osc) begin
            sleep_state_reg <= IWD_AWAKE;
          end else if (start_seen) begin
            sleep_state_reg <= IWD_OSC_UP;
            osc_cnt_reg <= 8'h00;
          end
        end
        IWD_OSC_UP: begin
          if (osc_sync_reg[1] && osc_cnt_reg >= `IWD_OSC_WAIT) begin
            sleep_state_reg <= IWD_ADDR;
          end else if (osc_sync_reg[1]) begin
            osc_cnt_reg <= osc_cnt_reg + 8'h01;
          end
        end
        IWD_ADDR: begin
          if (addr_valid && events.addr_match && main_reg[`IWD_B_ADIE]) begin
            sleep_state_reg <= IWD_HOLD;
          end else if (addr_valid) begin
            sleep_state_reg <= IWD_IDLE;
          end
        end
        IWD_HOLD: begin
          if (addr_match_clear || !events.addr_match) begin
            sleep_state_reg <= IWD_AWAKE;
          end
        end
        default: sleep_state_reg <= IWD_AWAKE;
      endcase
    end
  end

  // oscillator request from start until wake or mismatch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_request <= 1'b0;
    end else begin
      osc_request <= sleep_state_reg == IWD_OSC_UP || sleep_state_reg == IWD_ADDR ||
                     sleep_state_reg == IWD_HOLD;
    end
  end

  // wake request, first instance only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= sleep_state_reg == IWD_HOLD && FIRST_INSTANCE;
    end
  end

  // bus clock stretch while the oscillator starts and while the core wakes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_hold_low <= 1'b0;
    end else begin
      scl_hold_low <= sleep_state_reg == IWD_OSC_UP ||
                      (sleep_state_reg == IWD_HOLD && !addr_match_clear);
    end
  end
endmodule : iwd_ctrl

// ==== verif/iwd_ctrl_properties.sv ====
`timescale 1ns/1ns
module iwd_ctrl_chk
  import iwd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire iwd_events_s events,
  input wire iwd_faults_s faults,
  input wire logic [6:0] rx_addr,
  input wire logic addr_valid,
  input wire logic core_halted,
  input wire logic debug_freeze_select,
  input wire logic dma_tx_req,
  input wire logic dma_rx_req,
  input wire logic event_irq,
  input wire logic alert_pin_out,
  input wire logic alert_pin_oe,
  input wire logic alert_seen_flag,
  input wire logic timeout_run,
  input wire logic wake_request,
  input wire logic special_addr_ack,
  input wire logic [31:0] control_bits
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] cb;
  logic term;
  logic hit;
  logic frz;
  iwd_events_s ev_d;
  iwd_faults_s flt_d;
  logic alt_d;
  logic av_d;
  logic [6:0] ra_d;
  // inputs one cycle back, lined up with the control copy of the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_d <= '0;
      flt_d <= '0;
      alt_d <= 1'b0;
      av_d <= 1'b0;
      ra_d <= 7'h00;
    end else begin
      ev_d <= events;
      flt_d <= faults;
      alt_d <= alert_seen_flag;
      av_d <= addr_valid;
      ra_d <= rx_addr;
    end
  end
  // enabled event and error terms, special address decode, freeze request
  assign cb = control_bits;
  assign term = |({ev_d.rx_full, ev_d.tx_empty, ev_d.stop_seen, ev_d.addr_match,
    ev_d.not_ack, ev_d.count_reload | ev_d.transfer_done}
    & {cb[2], cb[1], cb[5], cb[3], cb[4], cb[6]}) | (cb[7] & (|flt_d | alt_d));
  assign hit = av_d && cb[0] && (cb[19] && ra_d == 7'h00 || cb[20] && ra_d == 7'h08
    || cb[21] && ra_d == 7'h61);
  assign frz = core_halted && debug_freeze_select;
  chk_dma_tx_pulse: assert property ($rose(events.tx_empty) && cb[14] |=> dma_tx_req)
    else $error("tx dma request missing");
  chk_dma_rx_cause: assert property (dma_rx_req |-> cb[15] && $past(events.rx_full))
    else $error("rx dma request without cause");
  chk_irq_or_term: assert property (event_irq == term)
    else $error("interrupt line wrong");
  chk_alert_drive: assert property (alert_pin_oe |-> !alert_pin_out && cb[22] && !cb[20])
    else $error("alert pin driven wrongly");
  chk_timeout_hold: assert property (timeout_run == !$past(frz))
    else $error("timeout run wrong in debug");
  chk_wake_cause: assert property (wake_request |-> cb[18] && cb[3])
    else $error("wake without enables");
  chk_wake_filter: assert property (cb[18] |-> cb[11:8] == 4'h0)
    else $error("wake enabled with filter");
  chk_lock_fields: assert property ($past(cb[0]) |->
    (cb & 32'h00021f00) == ($past(cb) & 32'h00021f00))
    else $error("locked field changed");
  chk_special_ack: assert property (special_addr_ack == hit)
    else $error("special address ack wrong");
endmodule : iwd_ctrl_chk
bind iwd_ctrl iwd_ctrl_chk u_chk (.*);

// ==== verif/iwd_remote.sv ====
`timescale 1ns/1ns
module iwd_remote (
  input wire logic pclk,
  input wire logic osc_request,
  input wire logic scl_hold_low,
  output logic osc_ready,
  output logic start_seen,
  output logic addr_valid,
  output logic [6:0] rx_addr,
  output logic scl_in
);
  logic run = 0;
  logic [7:0] sh = 0;
  int lag = 0;
  // oscillator comes up a settable number of cycles after the request
  always @(posedge pclk) sh <= {sh[6:0], osc_request};
  assign osc_ready = sh[lag];
  // bus clock toggles only inside a frame, rests high on the pull-up
  initial begin
    start_seen = 0;
    addr_valid = 0;
    rx_addr = 0;
    scl_in = 1;
    forever begin
      #62 scl_in = run ? ~scl_in : 1'b1;
      #63 scl_in = run ? ~scl_in : 1'b1;
    end
  end
  // start, wait while the clock is stretched, then one address byte
  task automatic frame(input logic [6:0] a);
    int n;
    n = 0;
    @(posedge pclk) start_seen <= 1;
    run <= 1;
    @(posedge pclk) start_seen <= 0;
    repeat (4) @(posedge pclk);
    while (scl_hold_low && n < 60) begin
      @(posedge pclk);
      n++;
    end
    rx_addr <= a;
    addr_valid <= 1;
    @(posedge pclk) addr_valid <= 0;
    rx_addr <= ~a;
    run <= 0;
  endtask : frame
endmodule : iwd_remote

// ==== verif/iwd_ctrl_tb.sv ====
`timescale 1ns/1ns
module iwd_ctrl_tb;
  import iwd_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, alert_low = 0;
  logic addr_match_clear = 0, deep_sleep = 0, kernel_is_fast_osc = 0, core_halted = 0;
  logic debug_freeze_select = 0, ack_seen = 0, osc_seen = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, control_bits, v;
  iwd_events_s events = '0;
  iwd_faults_s faults = '0;
  logic pready, pslverr, osc_request, wake_request, scl_hold_low, special_addr_ack;
  logic dma_tx_req, dma_rx_req, event_irq, alert_pin_out, alert_pin_oe, alert_seen_flag;
  logic timeout_run, osc_ready, start_seen, addr_valid, scl_in;
  logic [6:0] rx_addr;
  logic [6:0] tbl[4] = '{7'h00, 7'h08, 7'h61, 7'h33};
  wire alert_pin_in = !(alert_pin_oe && !alert_pin_out) && !alert_low;
  logic [31:0] exp_q[$];
  int bad_count = 0, tests_run = 0, cyc = 0;
  iwd_ctrl u_dut (.*);
  iwd_remote u_rem (.*);
  always #4 pclk = ~pclk;
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk) psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (!pready && ++n < 50);
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(0, a, 0);
  endtask : rd
  task automatic wait2();
    repeat (2) @(posedge pclk);
    #1;
  endtask : wait2
  // sticky markers of pulses, in-order read compare, run limit
  always @(posedge pclk) begin
    if (special_addr_ack) ack_seen <= 1;
    if (osc_request) osc_seen <= 1;
    if (psel && penable && pready && !pwrite) check(prdata, exp_q.pop_front());
    if (++cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  // main sequence
  initial begin
    void'($urandom(32'hf940));
    repeat (5) @(posedge pclk);
    presetn <= 1;
    rd(0, 0);
    rd(4, 0);
    apb(1, 0, 32'hffffffff);
    rd(0, 32'h00fbdfff);
    apb(1, 0, 0);
    rd(0, 32'h00021f00);
    apb(1, 0, 0);
    rd(12'h010, 0);
    v = $urandom;
    apb(1, 4, v);
    rd(4, v & 32'h07ffffff);
    apb(1, 0, 32'h0000c000);
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk) events <= i ? 7'h40 : 7'h20;
      @(posedge pclk) #1 check(32'({dma_rx_req, dma_tx_req}), i ? 2 : 1);
      @(posedge pclk) events <= '0;
    end
    apb(1, 0, 32'h000000ff);
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk) events <= 7'(1 << i);
      faults <= i == 7 ? 5'($urandom_range(31, 1)) : 5'h0;
      wait2();
      check(32'(event_irq), 1);
    end
    apb(1, 0, 0);
    wait2();
    check(32'(event_irq), 0);
    @(posedge pclk) faults <= '0;
    apb(1, 0, 32'h00400000);
    wait2();
    check(32'(alert_pin_in), 0);
    apb(1, 0, 32'h00500000);
    wait2();
    check(32'(alert_pin_oe), 0);
    apb(1, 12'h008, 32'h00080000);
    wait2();
    check(32'(alert_seen_flag), 0);
    @(posedge pclk) alert_low <= 1;
    repeat (6) @(posedge pclk);
    #1 check(32'(alert_seen_flag), 1);
    @(posedge pclk) alert_low <= 0;
    apb(1, 0, 32'h00380001);
    for (int i = 0; i < 4; i++) begin
      ack_seen <= 0;
      u_rem.frame(tbl[i]);
      wait2();
      check(32'(ack_seen), 32'(i < 3));
    end
    apb(1, 0, 32'h00140009);
    u_rem.lag = 5;
    @(posedge pclk) deep_sleep <= 1;
    kernel_is_fast_osc <= 1;
    events <= 7'h02;
    u_rem.frame(7'h08);
    repeat (10) @(posedge pclk);
    #1 check(32'({wake_request, scl_hold_low}), 3);
    @(posedge pclk) addr_match_clear <= 1;
    events <= '0;
    @(posedge pclk) addr_match_clear <= 0;
    wait2();
    check(32'({wake_request, scl_hold_low}), 0);
    osc_seen <= 0;
    u_rem.frame(7'h33);
    wait2();
    check(32'({osc_seen, wake_request, osc_request}), 4);
    @(posedge pclk) kernel_is_fast_osc <= 0;
    osc_seen <= 0;
    u_rem.frame(7'h08);
    wait2();
    check(32'({osc_seen, wake_request}), 0);
    @(posedge pclk) deep_sleep <= 0;
    apb(1, 0, 0);
    @(posedge pclk) core_halted <= 1;
    debug_freeze_select <= 1;
    wait2();
    check(32'(timeout_run), 0);
    @(posedge pclk) debug_freeze_select <= 0;
    wait2();
    check(32'(timeout_run), 1);
    stop_test();
  end
endmodule : iwd_ctrl_tb
